// [hbp_buf2.sv]
// two-entry valid/ready buffer holding the captured transmit words
`timescale 1ns/1ns
module hbp_buf2 #(
  parameter int W = 9
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  input wire logic [W-1:0] in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output logic [W-1:0] out_data_o,
  input wire logic out_ready_i
);
  logic [W-1:0] mem_r [2];
  logic [W-1:0] mem_nxt [2];
  logic wp_r, wp_nxt, rp_r, rp_nxt;
  logic [1:0] cnt_r, cnt_nxt;
  logic wr, rd;

  assign in_ready_o = (cnt_r != 2'h2);
  assign out_valid_o = (cnt_r != 2'h0);
  assign out_data_o = mem_r[rp_r];

  always_comb begin
    wr = in_valid_i && in_ready_o;
    rd = out_valid_o && out_ready_i;
    mem_nxt = mem_r;
    wp_nxt = wp_r;
    rp_nxt = rp_r;
    cnt_nxt = cnt_r;
    if (wr) begin
      mem_nxt[wp_r] = in_data_i;
      wp_nxt = ~wp_r;
    end
    if (rd) begin
      rp_nxt = ~rp_r;
    end
    if (wr && !rd) begin
      cnt_nxt = cnt_r + 2'h1;
    end else if (rd && !wr) begin
      cnt_nxt = cnt_r - 2'h1;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      mem_r[0] <= '0;
      mem_r[1] <= '0;
      wp_r <= 1'b0;
      rp_r <= 1'b0;
      cnt_r <= 2'h0;
    end else begin
      mem_r <= mem_nxt;
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  property p_buf_fill;
    @(posedge clock_i) disable iff (rst_i)
      (cnt_r == 2'h1) && in_valid_i && !out_ready_i |=> !in_ready_o;
  endproperty
  a_buf_fill: assert property (p_buf_fill) else $error("buffer did not fill");
endmodule : hbp_buf2

// [hbp_main.sv]
// package and top module of the hdlc byte port
// Behaviour
// - capture transmit byte while send-message high
// - captured bytes fill frame payload in order
// - check-append starts check trailer insertion
// - select bit chooses 32- or 16-bit check
// - frames go out as payload bits
// - idle payload carries continuous flag octets
// - idle indicator raised with each flag, held until the next receive byte event
// - good frame end: idle and valid high
// - bad frame end: idle high, valid low
// - abort: idle low, valid high
// - receive bus changes on byte clock rise
// - stuff zeros, byte clock may slow
`timescale 1ns/1ns
package hbp_pkg;
  localparam int CLK_NS = 10;
  localparam int TBC_HALF_NS = 40;
  localparam int TBC_HALF_CYC = (TBC_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0] FLAG = 8'h7E;
  localparam logic [7:0] ABORT_BYTE = 8'hFF;
  localparam logic [2:0] STUFF_ONES = 3'h5;
  localparam logic [31:0] CRC16_POLY = 32'h0000_8408;
  localparam logic [31:0] CRC32_POLY = 32'hEDB8_8320;
  localparam logic [31:0] CRC16_INIT = 32'h0000_FFFF;
  localparam logic [31:0] CRC32_INIT = 32'hFFFF_FFFF;
  localparam logic [31:0] CRC16_GOOD = 32'h0000_F0B8;
  localparam logic [31:0] CRC32_GOOD = 32'hDEBB_20E3;
  typedef enum logic [1:0] {
    S_IDLE = 2'b00, S_DATA = 2'b01, S_FCS = 2'b10, S_ABORT = 2'b11
  } hbp_txst_t;

  function automatic logic [31:0] crc_init(input logic w);
    crc_init = w ? CRC32_INIT : CRC16_INIT;
  endfunction : crc_init

  // one reflected crc step, lsb first
  function automatic logic [31:0] crc_step(input logic [31:0] c, input logic b, input logic w);
    logic [31:0] n;
    n = {1'b0, c[31:1]} ^ ((c[0] ^ b) ? (w ? CRC32_POLY : CRC16_POLY) : 32'h0);
    crc_step = w ? n : (n & CRC16_INIT);
  endfunction : crc_step

  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d,
                                           input logic w);
    logic [31:0] t;
    t = c;
    for (int i = 0; i < 8; i++) begin
      t = crc_step(t, d[i], w);
    end
    crc_byte = t;
  endfunction : crc_byte
endpackage : hbp_pkg

module hbp_main import hbp_pkg::*; (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic send_msg_i,
  input wire logic append_check_i,
  input wire logic [7:0] tx_byte_bus_i,
  input wire logic crc32_sel_i,
  output logic tx_byte_clock_o,
  input wire logic payload_bit_req_i,
  output logic payload_bit_o,
  input wire logic rx_bit_valid_i,
  input wire logic rx_bit_i,
  output logic rx_byte_clock_o,
  output logic [7:0] rx_byte_bus_o,
  output logic rx_idle_indicator_o,
  output logic rx_check_valid_o
);
  // transmit byte clock and capture
  logic tclk_r, tclk_nxt, chk_r, chk_nxt, rise, push, in_ready;
  logic [3:0] tdiv_r, tdiv_nxt;
  logic [8:0] pdata, bod;
  logic bov, pop;

  always_comb begin
    tclk_nxt = tclk_r;
    tdiv_nxt = tdiv_r;
    chk_nxt = chk_r;
    rise = 1'b0;
    push = 1'b0;
    pdata = 9'h000;
    if (tdiv_r != 4'(TBC_HALF_CYC - 1)) begin
      tdiv_nxt = tdiv_r + 4'h1;
    end else if (tclk_r) begin
      tclk_nxt = 1'b0;
      tdiv_nxt = 4'h0;
    end else if (in_ready) begin
      // clock held low while buffer is full
      tclk_nxt = 1'b1;
      tdiv_nxt = 4'h0;
      rise = 1'b1;
    end
    if (rise) begin
      if (append_check_i) begin
        // only the first period of a held strobe counts
        push = !chk_r;
        pdata = {1'b1, 8'h00};
        chk_nxt = 1'b1;
      end else begin
        chk_nxt = 1'b0;
        push = send_msg_i;
        pdata = {1'b0, tx_byte_bus_i};
      end
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      tclk_r <= 1'b0;
      tdiv_r <= 4'h0;
      chk_r <= 1'b0;
    end else begin
      tclk_r <= tclk_nxt;
      tdiv_r <= tdiv_nxt;
      chk_r <= chk_nxt;
    end
  end
  assign tx_byte_clock_o = tclk_r;

  hbp_buf2 #(.W(9)) u_buf (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .in_valid_i(push),
    .in_data_i(pdata),
    .in_ready_o(in_ready),
    .out_valid_o(bov),
    .out_data_o(bod),
    .out_ready_i(pop)
  );

  // transmit serializer
  hbp_txst_t st_r, st_nxt;
  logic [7:0] sh_r, sh_nxt;
  logic [2:0] cnt_r, cnt_nxt, ones_r, ones_nxt;
  logic [31:0] crc_r, crc_nxt, fcs_r, fcs_nxt, f;
  logic [1:0] fidx_r, fidx_nxt;
  logic wide_r, wide_nxt, tbit_r, tbit_nxt, ld;

  always_comb begin
    st_nxt = st_r;
    sh_nxt = sh_r;
    cnt_nxt = cnt_r;
    ones_nxt = ones_r;
    crc_nxt = crc_r;
    fcs_nxt = fcs_r;
    fidx_nxt = fidx_r;
    wide_nxt = wide_r;
    tbit_nxt = tbit_r;
    ld = 1'b0;
    pop = 1'b0;
    f = 32'h0;
    if (payload_bit_req_i) begin
      if (ones_r == STUFF_ONES) begin
        tbit_nxt = 1'b0;
        ones_nxt = 3'h0;
      end else begin
        tbit_nxt = sh_r[0];
        sh_nxt = {1'b0, sh_r[7:1]};
        cnt_nxt = cnt_r + 3'h1;
        ones_nxt = ((st_r == S_DATA || st_r == S_FCS) && sh_r[0]) ? ones_r + 3'h1 : 3'h0;
        if (st_r == S_DATA) begin
          crc_nxt = crc_step(crc_r, sh_r[0], wide_r);
        end
        ld = (cnt_r == 3'h7);
      end
    end
    if (ld) begin
      sh_nxt = FLAG;
      case (st_r)
        S_IDLE: begin
          pop = bov;
          if (bov && !bod[8]) begin
            sh_nxt = bod[7:0];
            st_nxt = S_DATA;
            wide_nxt = crc32_sel_i;
            crc_nxt = crc_init(crc32_sel_i);
          end
        end
        S_DATA: begin
          pop = bov;
          if (!bov) begin
            sh_nxt = ABORT_BYTE;
            st_nxt = S_ABORT;
          end else if (bod[8]) begin
            f = ~crc_nxt;
            sh_nxt = f[7:0];
            fcs_nxt = {8'h00, f[31:8]};
            fidx_nxt = wide_r ? 2'h3 : 2'h1;
            st_nxt = S_FCS;
          end else begin
            sh_nxt = bod[7:0];
          end
        end
        S_FCS: begin
          if (fidx_r != 2'h0) begin
            sh_nxt = fcs_r[7:0];
            fcs_nxt = {8'h00, fcs_r[31:8]};
            fidx_nxt = fidx_r - 2'h1;
          end else begin
            st_nxt = S_IDLE;
          end
        end
        default: st_nxt = S_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      st_r <= S_IDLE;
      sh_r <= FLAG;
      cnt_r <= 3'h0;
      ones_r <= 3'h0;
      crc_r <= CRC32_INIT;
      fcs_r <= 32'h0;
      fidx_r <= 2'h0;
      wide_r <= 1'b0;
      tbit_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      sh_r <= sh_nxt;
      cnt_r <= cnt_nxt;
      ones_r <= ones_nxt;
      crc_r <= crc_nxt;
      fcs_r <= fcs_nxt;
      fidx_r <= fidx_nxt;
      wide_r <= wide_nxt;
      tbit_r <= tbit_nxt;
    end
  end
  assign payload_bit_o = tbit_r;

  // receive deframer
  logic [2:0] rones_r, rones_nxt, nb_r, nb_nxt, hn_r, hn_nxt, clen;
  logic [7:0] acc_r, acc_nxt, rbus_r, rbus_nxt, evb, b;
  logic [31:0] rcrc_r, rcrc_nxt, h_r, h_nxt;
  logic inf_r, inf_nxt, rclk_r, ridle_r, ridle_nxt, rval_r, rval_nxt;
  logic ev, evi, evv, shift, sb, fl, ab, good;

  always_comb begin
    rones_nxt = rones_r;
    acc_nxt = acc_r;
    nb_nxt = nb_r;
    hn_nxt = hn_r;
    rcrc_nxt = rcrc_r;
    h_nxt = h_r;
    inf_nxt = inf_r;
    rbus_nxt = rbus_r;
    ridle_nxt = ridle_r;
    rval_nxt = rval_r;
    ev = 1'b0;
    evb = rbus_r;
    evi = 1'b0;
    evv = 1'b0;
    shift = 1'b0;
    sb = rx_bit_i;
    fl = 1'b0;
    ab = 1'b0;
    b = {sb, acc_r[7:1]};
    clen = crc32_sel_i ? 3'h4 : 3'h2;
    good = (rcrc_r == (crc32_sel_i ? CRC32_GOOD : CRC16_GOOD));
    if (rx_bit_valid_i) begin
      if (rx_bit_i) begin
        if (rones_r != 3'h7) begin
          rones_nxt = rones_r + 3'h1;
        end
        shift = (rones_r < STUFF_ONES);
        ab = (rones_r == 3'h6);
      end else begin
        rones_nxt = 3'h0;
        fl = (rones_r == 3'h6);
        // a zero after five ones is stuffing and is dropped
        shift = (rones_r < STUFF_ONES);
      end
    end
    if (shift && inf_r) begin
      acc_nxt = b;
      nb_nxt = nb_r + 3'h1;
      if (nb_r == 3'h7) begin
        rcrc_nxt = crc_byte(rcrc_r, b, crc32_sel_i);
        h_nxt = {h_r[23:0], b};
        // last clen bytes are held back so the check never shows
        if (hn_r == clen) begin
          ev = 1'b1;
          evb = crc32_sel_i ? h_r[31:24] : h_r[15:8];
        end else begin
          hn_nxt = hn_r + 3'h1;
        end
      end
    end
    if (fl) begin
      ev = 1'b1;
      evb = FLAG;
      evi = 1'b1;
      evv = inf_r && (hn_r == clen) && (nb_r == 3'h6) && good;
      inf_nxt = 1'b1;
      nb_nxt = 3'h0;
      hn_nxt = 3'h0;
      rcrc_nxt = crc_init(crc32_sel_i);
    end
    if (ab) begin
      ev = 1'b1;
      evv = 1'b1;
      inf_nxt = 1'b0;
    end
    if (ev) begin
      rbus_nxt = evb;
      ridle_nxt = evi;
      rval_nxt = evv;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rones_r <= 3'h0;
      acc_r <= 8'h00;
      nb_r <= 3'h0;
      hn_r <= 3'h0;
      rcrc_r <= CRC32_INIT;
      h_r <= 32'h0;
      inf_r <= 1'b0;
      rclk_r <= 1'b0;
      rbus_r <= 8'h00;
      ridle_r <= 1'b0;
      rval_r <= 1'b0;
    end else begin
      rones_r <= rones_nxt;
      acc_r <= acc_nxt;
      nb_r <= nb_nxt;
      hn_r <= hn_nxt;
      rcrc_r <= rcrc_nxt;
      h_r <= h_nxt;
      inf_r <= inf_nxt;
      rclk_r <= ev;
      rbus_r <= rbus_nxt;
      ridle_r <= ridle_nxt;
      rval_r <= rval_nxt;
    end
  end
  assign rx_byte_clock_o = rclk_r;
  assign rx_byte_bus_o = rbus_r;
  assign rx_idle_indicator_o = ridle_r;
  assign rx_check_valid_o = rval_r;

  // the byte is taken at the edge that raises the byte clock, so look one cycle back
  property p_capture;
    @(posedge clock_i) disable iff (rst_i)
      $rose(tx_byte_clock_o) && $past(send_msg_i) && !$past(append_check_i) |->
        $past(push) && $past(pdata) == {1'b0, $past(tx_byte_bus_i)};
  endproperty
  a_capture: assert property (p_capture) else $error("byte not captured");
  property p_order;
    @(posedge clock_i) disable iff (rst_i)
      ld && st_r == S_DATA && bov && !bod[8] |=> sh_r == $past(bod[7:0]);
  endproperty
  a_order: assert property (p_order) else $error("payload byte not loaded");
  property p_fcs_start;
    @(posedge clock_i) disable iff (rst_i)
      ld && st_r == S_DATA && bov && bod[8] |=> st_r == S_FCS && sh_r == ~$past(crc_nxt[7:0]);
  endproperty
  a_fcs_start: assert property (p_fcs_start) else $error("check not started");
  property p_fcs_len;
    @(posedge clock_i) disable iff (rst_i)
      $rose(st_r == S_FCS) |-> fidx_r == (wide_r ? 2'h3 : 2'h1);
  endproperty
  a_fcs_len: assert property (p_fcs_len) else $error("check length wrong");
  property p_flags;
    @(posedge clock_i) disable iff (rst_i)
      ld && st_r == S_IDLE && !bov |=> sh_r == FLAG && st_r == S_IDLE;
  endproperty
  a_flags: assert property (p_flags) else $error("idle flag missing");
  property p_stuff;
    @(posedge clock_i) disable iff (rst_i)
      payload_bit_req_i && ones_r == STUFF_ONES |=> !payload_bit_o && ones_r == 3'h0;
  endproperty
  a_stuff: assert property (p_stuff) else $error("zero not stuffed");
  property p_idle;
    @(posedge clock_i) disable iff (rst_i)
      fl |=> rx_idle_indicator_o && rx_byte_clock_o && rx_byte_bus_o == FLAG;
  endproperty
  a_idle: assert property (p_idle) else $error("idle not raised");
  property p_good;
    @(posedge clock_i) disable iff (rst_i)
      fl && inf_r && hn_r == clen && nb_r == 3'h6 |=> rx_idle_indicator_o && rx_check_valid_o == $past(good);
  endproperty
  a_good: assert property (p_good) else $error("frame end wrong");
  property p_abort;
    @(posedge clock_i) disable iff (rst_i)
      ab |=> !rx_idle_indicator_o && rx_check_valid_o ##1 !rx_byte_clock_o;
  endproperty
  a_abort: assert property (p_abort) else $error("abort not shown");
  property p_rxbus;
    @(posedge clock_i) disable iff (rst_i)
      $changed(rx_byte_bus_o) |-> $rose(rx_byte_clock_o);
  endproperty
  a_rxbus: assert property (p_rxbus) else $error("bus changed off edge");
  c_fcs: cover property (@(posedge clock_i) disable iff (rst_i) st_r == S_FCS && wide_r);
  c_good: cover property (@(posedge clock_i) disable iff (rst_i) fl && evv);
  c_abort: cover property (@(posedge clock_i) disable iff (rst_i) ab);
  c_full: cover property (@(posedge clock_i) disable iff (rst_i) !in_ready && !tclk_r);
endmodule : hbp_main

// [hbp_term_model.sv]
// terminal equipment and payload line loopback model for the hdlc byte port
`timescale 1ns/1ns
module hbp_term_model import hbp_pkg::*; (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic tx_byte_clock_i,
  output logic send_msg_o,
  output logic append_check_o,
  output logic [7:0] tx_byte_bus_o,
  output logic payload_bit_req_o,
  input wire logic payload_bit_i,
  output logic rx_bit_valid_o,
  output logic rx_bit_o,
  input wire logic slow_i,
  input wire logic flip_i
);
  logic [2:0] gap_r;
  logic [1:0] fed_r;
  logic flipped_r;
  logic flip_now;

  initial begin
    send_msg_o = 1'b0;
    append_check_o = 1'b0;
    tx_byte_bus_o = 8'h00;
    payload_bit_req_o = 1'b0;
    rx_bit_valid_o = 1'b0;
    rx_bit_o = 1'b0;
    gap_r = 3'h0;
    fed_r = 2'h0;
    flipped_r = 1'b0;
  end

  // bytes change on the byte clock fall so that its rise finds them settled
  task automatic send_frame(input logic [7:0] d[$], input int hold, input logic cut);
    foreach (d[i]) begin
      @(negedge tx_byte_clock_i);
      send_msg_o <= 1'b1;
      tx_byte_bus_o <= d[i];
    end
    @(negedge tx_byte_clock_i);
    send_msg_o <= 1'b0;
    tx_byte_bus_o <= ~tx_byte_bus_o;
    if (!cut) begin
      append_check_o <= 1'b1;
      repeat (hold) @(negedge tx_byte_clock_i);
      append_check_o <= 1'b0;
    end
  endtask : send_frame

  // a flip turns one zero payload bit into a one, once for each time flip_i is raised
  assign flip_now = fed_r[1] & flip_i & ~flipped_r & ~payload_bit_i;

  // each requested bit comes back as a received bit two cycles later
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      gap_r <= 3'h0;
      fed_r <= 2'h0;
      flipped_r <= 1'b0;
      payload_bit_req_o <= 1'b0;
      rx_bit_valid_o <= 1'b0;
      rx_bit_o <= 1'b0;
    end else begin
      payload_bit_req_o <= (gap_r == 3'h0);
      fed_r <= {fed_r[0], gap_r == 3'h0};
      gap_r <= (gap_r == 3'h0) ? (slow_i ? 3'h6 : 3'h2) : gap_r - 3'h1;
      rx_bit_valid_o <= fed_r[1];
      rx_bit_o <= fed_r[1] ? (payload_bit_i | flip_now) : ~rx_bit_o;
      flipped_r <= flip_i & (flipped_r | flip_now);
    end
  end
endmodule : hbp_term_model

// [tb_top.sv]
// self-checking bench: frames looped from the transmit to the receive byte port
`timescale 1ns/1ns
module tb_top import hbp_pkg::*; ();
  typedef struct {logic idl; logic vld; logic any; logic [7:0] b;} hbp_note_t;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic send_msg, append_check, crc32_sel = 1'b0, slow = 1'b0, flip = 1'b0;
  logic [7:0] tx_bus, rx_bus;
  logic tx_clk, req, pbit, rxv, rxb, rx_clk, idle, valid;
  hbp_note_t notes[$];
  int miscompares = 0;
  int checked = 0;
  int low_run = 0;
  int low_max = 0;

  always #5 clock_i = ~clock_i;

  hbp_main hbp_main_i (.clock_i(clock_i), .rst_i(rst_i), .send_msg_i(send_msg),
    .append_check_i(append_check), .tx_byte_bus_i(tx_bus), .crc32_sel_i(crc32_sel),
    .tx_byte_clock_o(tx_clk), .payload_bit_req_i(req), .payload_bit_o(pbit),
    .rx_bit_valid_i(rxv), .rx_bit_i(rxb), .rx_byte_clock_o(rx_clk),
    .rx_byte_bus_o(rx_bus), .rx_idle_indicator_o(idle), .rx_check_valid_o(valid));

  hbp_term_model hbp_term_model_i (.clock_i(clock_i), .rst_i(rst_i),
    .tx_byte_clock_i(tx_clk), .send_msg_o(send_msg), .append_check_o(append_check),
    .tx_byte_bus_o(tx_bus), .payload_bit_req_o(req), .payload_bit_i(pbit),
    .rx_bit_valid_o(rxv), .rx_bit_o(rxb), .slow_i(slow), .flip_i(flip));

  task automatic print_verdict();
    if (miscompares == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : print_verdict

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
    end
  endtask : check

  function automatic void note(input logic i, input logic v, input logic a, input logic [7:0] b);
    hbp_note_t n;
    n.idl = i;
    n.vld = v;
    n.any = a;
    n.b = b;
    notes.push_back(n);
  endfunction : note

  task automatic wait_drain();
    int k;
    k = 0;
    while (notes.size() != 0 && k < 20000) begin
      @(posedge clock_i);
      k++;
    end
    check("pending receive events", 32'h0, 32'(notes.size()));
  endtask : wait_drain

  // zero frames carry a flipped bit and end bad; cut frames underrun into an abort
  task automatic frame(input int len, input logic sel, input int hold, input logic zero,
                       input logic cut, input logic sl);
    logic [7:0] d[$];
    logic [7:0] b;
    if (crc32_sel !== sel) wait_drain();
    @(posedge clock_i);
    crc32_sel <= sel;
    slow <= sl;
    for (int i = 0; i < len; i++) begin
      b = zero ? 8'h00 : 8'($urandom());
      d.push_back(b);
      if (!cut) note(1'b0, 1'b0, zero, b);
    end
    if (cut) note(1'b0, 1'b1, 1'b1, FLAG);
    else note(1'b1, !zero, 1'b0, FLAG);
    hbp_term_model_i.send_frame(d, hold, cut);
  endtask : frame

  always @(posedge clock_i) begin
    low_run <= (tx_clk === 1'b0 && rst_i === 1'b0) ? low_run + 1 : 0;
    if (low_run > low_max) low_max <= low_run;
  end

  // receive bus sampled on the byte clock fall
  always @(negedge rx_clk) begin : watch
    hbp_note_t n;
    if (idle === 1'b1 && valid === 1'b0 && (notes.size() == 0 || notes[0].idl !== 1'b1)) begin
      check("idle flag byte", {24'h0, FLAG}, {24'h0, rx_bus});
    end else if (notes.size() == 0) begin
      check("receive event", 32'h0, 32'h1);
    end else begin
      n = notes.pop_front();
      check("idle indicator", {31'h0, n.idl}, {31'h0, idle});
      check("check valid", {31'h0, n.vld}, {31'h0, valid});
      if (!n.any) check("receive byte", {24'h0, n.b}, {24'h0, rx_bus});
      if (n.any && !n.idl && !n.vld) flip <= 1'b1;
    end
  end

  initial begin : main
    logic [7:0] sh;
    sh = 8'h00;
    void'($urandom(47));
    repeat (2) @(posedge clock_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      @(posedge clock_i iff rxv === 1'b1);
      sh = {rxb, sh[7:1]};
    end
    check("idle octet on line", {24'h0, FLAG}, {24'h0, sh});
    // back-to-back frames of both widths and a stalling line
    for (int i = 0; i < 5; i++) begin
      frame(3 + int'($urandom() % 6), i == 2 || i == 3, (i == 2 || i == 3) ? 4 : 2, 1'b0,
            1'b0, i >= 3);
    end
    wait_drain();
    frame(2, 1'b0, 2, 1'b0, 1'b1, 1'b0);
    wait_drain();
    frame(8, 1'b0, 2, 1'b1, 1'b0, 1'b0);
    wait_drain();
    flip <= 1'b0;
    check("byte clock stretched", 32'h1, {31'h0, low_max > 4});
    repeat (100) @(posedge clock_i);
    print_verdict();
  end

  initial begin : watchdog
    repeat (60000) @(posedge clock_i);
    miscompares++;
    print_verdict();
  end
endmodule : tb_top
